/* File: rtl/fnm_modulation_ctrl.sv */
// Fractional-N divider control and modulation selector with AXI4-Lite access
//
// Added by the designer: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
//
// Contract
// - Sigma-delta divider with fifteen-bit fractional resolution
// - Fraction plus signed eleven-bit trim forms value
// - Prescaler 4/5 or 8/9, minimum P squared+3P+3
// - Eight-bit integer part, up to 255
// - Largest integer plus fraction approaches 256
// - Fraction step equals comparison rate over 4096
// - Trim is two's complement, resets to zero
// - FSK shifts centre by deviation per bit
// - FSK deviation is seven-bit number, 1..127
// - Both select bits zero selects FSK
// - GFSK bits pass a Gaussian pre-filter
// - GFSK bit clock out; host syncs data
// - GFSK deviation is two to exponent
// - Bit rate is rate over factor times index
// - ASK picks low or high power code
// - High select one, low zero selects ASK
// - OOK drives high code or switches off
// - Both select bits one selects OOK
// - Twenty-four-bit words shifted MSB first, latched
// - Two word LSBs choose holding register
module fnm_modulation_ctrl
  import fnm_pkg::*;
#(
  parameter int PFD_DIV = FNM_PFD_DIV_DEF
) (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic SER_CLK,
  input wire logic SER_DATA,
  input wire logic LATCH_STROBE,
  input wire logic TRANSMIT_BIT_IN,
  input wire logic [4:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [4:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic TRANSMIT_BIT_CLOCK,
  output logic [FNM_NTOT_W-1:0] N_TOTAL,
  output logic [6:0] FB_COUNT_B,
  output logic [2:0] FB_COUNT_A,
  output logic PRESC_EIGHT,
  output logic [6:0] POWER_CODE,
  output logic OUTPUT_STAGE_ON
);
  // Refuse a divider that cannot produce a tick
  if (PFD_DIV < 1 || PFD_DIV > 255) begin : g_bad_pfd_div
    $error("PFD_DIV must lie in 1..255");
  end

  // Whole state of the block
  typedef struct packed {
    logic sclk_s1, sclk_s2, sclk_d;   // Serial clock sync and edge
    logic sdat_s1, sdat_s2;           // Serial data sync
    logic le_s1, le_s2, le_d;         // Latch strobe sync and edge
    logic txd_s1, txd_s2;             // Transmit bit sync
    logic [FNM_WORD_W-1:0] shift;     // Incoming word
    logic [3:0][FNM_WORD_W-1:0] hold; // Holding registers
    logic [7:0] pfd_cnt;              // Comparison rate divider
    logic pfd_tick;
    logic [7:0] smp_cnt;              // Divider factor counter
    logic smp_tick;
    logic [6:0] idx_cnt;              // Index counter within a bit
    logic tx_bit;                     // GFSK bit sampled on the bit clock
    logic bit_clk;
    logic [FNM_NTOT_W-1:0] n_total;
    logic clamped;
    logic [6:0] fb_b;
    logic [2:0] fb_a;
    logic presc8;
    logic [6:0] power;
    logic stage_on;
    fnm_wr_t wr_state;
    logic aw_got, w_got, awready, wready;
    logic [4:0] aw_addr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    fnm_rd_t rd_state;
    logic arready, rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } fnm_state_t;

  fnm_state_t st;
  fnm_state_t next_st;

  // Word-aligned decode of a bus address, used for reads and writes
  function automatic logic [2:0] fnm_reg_idx(input logic [4:0] addr);
    logic [2:0] idx;
    idx = FNM_IDX_NONE;
    if (addr[1:0] == 2'b00 && addr[4:2] <= FNM_IDX_STATUS) begin
      idx = addr[4:2];
    end
    return idx;
  endfunction : fnm_reg_idx

  // Decoded settings and divide arithmetic
  fnm_mod_t mode;
  logic [FNM_FRAC_W-1:0] frac;
  logic [FNM_INT_W-1:0] int_part;
  logic [FNM_TRIM_W-1:0] trim;
  logic [6:0] high_code;
  logic [6:0] low_code;
  logic [2:0] dev_exp;
  logic [7:0] divf;
  logic [6:0] index_val;
  logic [6:0] half_idx;
  logic [7:0] nmin;
  logic data_bit;
  logic signed [8:0] dev;
  logic signed [14:0] gprod;
  logic [25:0] base;
  logic [25:0] tot;
  logic [25:0] tot_min;
  logic [25:0] tot_max;
  logic [2:0] wr_idx;
  logic [2:0] rd_idx;
  logic [8:0] sd_n_inst;
  logic signed [5:0] g_level;

  // Sigma-delta modulus sequence, stepped at the comparison rate
  fnm_sigma_delta u_sd (
    .clk(CLOCK),
    .rst_n(RST_N),
    .en(st.pfd_tick),
    .n_total(st.n_total),
    .n_inst(sd_n_inst)
  );

  // Gaussian shaping, oversampled at comparison rate over divider factor
  fnm_gauss u_gauss (
    .clk(CLOCK),
    .rst_n(RST_N),
    .en(st.smp_tick),
    .bit_in(st.tx_bit),
    .level(g_level)
  );

  // Next-state logic
  always_comb begin
    next_st = st;
    // Field views, taken only from the holding registers
    mode = fnm_mod_t'({st.hold[FNM_HOLD_M][FNM_SEL_HIGH_BIT], st.hold[FNM_HOLD_M][FNM_SEL_LOW_BIT]});
    frac = st.hold[FNM_HOLD_N][FNM_FRAC_LSB +: FNM_FRAC_W];
    int_part = st.hold[FNM_HOLD_N][FNM_INT_LSB +: FNM_INT_W];
    trim = st.hold[FNM_HOLD_R][FNM_TRIM_LSB +: FNM_TRIM_W];
    high_code = st.hold[FNM_HOLD_M][FNM_HIGH_PWR_LSB +: FNM_PWR_W];
    low_code = st.hold[FNM_HOLD_M][FNM_LOW_PWR_LSB +: FNM_PWR_W];
    dev_exp = st.hold[FNM_HOLD_M][FNM_EXP_LSB +: FNM_EXP_W];
    divf = st.hold[FNM_HOLD_G][FNM_DIVF_LSB +: FNM_DIVF_W];
    index_val = st.hold[FNM_HOLD_G][FNM_INDEX_LSB +: FNM_INDEX_W];
    half_idx = 7'((8'(index_val) + 8'h01) >> 1);
    nmin = st.presc8 ? FNM_NMIN_P8 : FNM_NMIN_P4;
    // Synchronisers, first stage read only by the second
    next_st.sclk_s1 = SER_CLK;
    next_st.sclk_s2 = st.sclk_s1;
    next_st.sclk_d = st.sclk_s2;
    next_st.sdat_s1 = SER_DATA;
    next_st.sdat_s2 = st.sdat_s1;
    next_st.le_s1 = LATCH_STROBE;
    next_st.le_s2 = st.le_s1;
    next_st.le_d = st.le_s2;
    next_st.txd_s1 = TRANSMIT_BIT_IN;
    next_st.txd_s2 = st.txd_s1;
    // Shift MSB first on serial clock rising edge
    if (st.sclk_s2 && !st.sclk_d) begin
      next_st.shift = {st.shift[FNM_WORD_W-2:0], st.sdat_s2};
    end
    // Latch strobe rising edge moves the word to its holding register
    if (st.le_s2 && !st.le_d) begin
      next_st.hold[st.shift[1:0]] = st.shift;
    end
    // Comparison rate tick
    next_st.pfd_tick = 1'b0;
    if (st.pfd_cnt == 8'(PFD_DIV - 1)) begin
      next_st.pfd_cnt = 8'h00;
      next_st.pfd_tick = 1'b1;
    end else begin
      next_st.pfd_cnt = st.pfd_cnt + 8'h01;
    end
    // Divider factor tick, a zero factor acts as one
    next_st.smp_tick = 1'b0;
    if (st.pfd_tick) begin
      if (divf == 8'h00 || st.smp_cnt >= divf - 8'h01) begin
        next_st.smp_cnt = 8'h00;
        next_st.smp_tick = 1'b1;
      end else begin
        next_st.smp_cnt = st.smp_cnt + 8'h01;
      end
    end
    // Index counter paces bits; clock high in first half of each bit
    if (st.smp_tick) begin
      if (index_val == 7'h00 || st.idx_cnt >= index_val - 7'h01) begin
        next_st.idx_cnt = 7'h00;
        next_st.tx_bit = st.txd_s2;
      end else begin
        next_st.idx_cnt = st.idx_cnt + 7'h01;
      end
      next_st.bit_clk = next_st.idx_cnt < half_idx;
    end
    // Deviation in units of the fraction step
    data_bit = (mode == FNM_MOD_GFSK) ? st.tx_bit : st.txd_s2;
    gprod = $signed({6'h00, 9'(9'h001 << dev_exp)}) * 15'(g_level);
    dev = 9'sh000;
    case (mode)
      FNM_MOD_FSK: begin
        dev = data_bit ? $signed({2'b00, low_code}) : -$signed({2'b00, low_code});
      end
      FNM_MOD_GFSK: begin
        dev = 9'(gprod >>> 4);
      end
      default: begin
        dev = 9'sh000;
      end
    endcase
    // Total divide in 2^-15 units: integer, fraction, trim, deviation
    base = {3'b000, int_part, 15'h0000} + {11'h000, frac, 3'b000}
         + {{15{trim[FNM_TRIM_W-1]}}, trim};
    tot = base + {{14{dev[8]}}, dev, 3'b000};
    tot_min = {3'b000, nmin, 15'h0000};
    tot_max = {3'b000, FNM_INT_MAX, 15'h7FFF};
    next_st.clamped = 1'b1;
    if ($signed(tot) < $signed(tot_min)) begin
      next_st.n_total = tot_min[FNM_NTOT_W-1:0];
    end else if ($signed(tot) > $signed(tot_max)) begin
      next_st.n_total = tot_max[FNM_NTOT_W-1:0];
    end else begin
      next_st.n_total = tot[FNM_NTOT_W-1:0];
      next_st.clamped = 1'b0;
    end
    // Dual-modulus split of the current modulus
    next_st.presc8 = st.hold[FNM_HOLD_N][FNM_PRESC_BIT];
    next_st.fb_b = st.presc8 ? 7'(sd_n_inst >> 3) : 7'(sd_n_inst >> 2);
    next_st.fb_a = st.presc8 ? sd_n_inst[2:0] : {1'b0, sd_n_inst[1:0]};
    // Output stage power code
    case (mode)
      FNM_MOD_ASK: begin
        next_st.power = data_bit ? high_code : low_code;
        next_st.stage_on = 1'b1;
      end
      FNM_MOD_OOK: begin
        next_st.power = data_bit ? high_code : 7'h00;
        next_st.stage_on = data_bit;
      end
      default: begin
        next_st.power = high_code;
        next_st.stage_on = 1'b1;
      end
    endcase
    // Bus write: address and data in either order
    if (S_AXI_AWVALID && st.awready) begin
      next_st.aw_got = 1'b1;
      next_st.aw_addr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && st.wready) begin
      next_st.w_got = 1'b1;
      next_st.wdata = S_AXI_WDATA;
      next_st.wstrb = S_AXI_WSTRB;
    end
    wr_idx = fnm_reg_idx(st.aw_addr);
    case (st.wr_state)
      FNM_WR_COLLECT: begin
        if (st.aw_got && st.w_got) begin
          next_st.aw_got = 1'b0;
          next_st.w_got = 1'b0;
          next_st.bvalid = 1'b1;
          next_st.wr_state = FNM_WR_RESP;
          next_st.bresp = FNM_RESP_SLVERR;
          // Direct word load, behaves as a latch event
          if (wr_idx == FNM_IDX_CFG && st.wstrb[2:0] == 3'b111) begin
            next_st.hold[st.wdata[1:0]] = st.wdata[FNM_WORD_W-1:0];
            next_st.bresp = FNM_RESP_OKAY;
          end
        end
      end
      FNM_WR_RESP: begin
        if (S_AXI_BREADY) begin
          next_st.bvalid = 1'b0;
          next_st.wr_state = FNM_WR_COLLECT;
        end
      end
      default: begin
        next_st.wr_state = FNM_WR_COLLECT;
      end
    endcase
    next_st.awready = !next_st.aw_got && next_st.wr_state == FNM_WR_COLLECT;
    next_st.wready = !next_st.w_got && next_st.wr_state == FNM_WR_COLLECT;
    // Bus read: data registered on the same edge that takes the address
    rd_idx = fnm_reg_idx(S_AXI_ARADDR);
    case (st.rd_state)
      FNM_RD_IDLE: begin
        if (S_AXI_ARVALID && st.arready) begin
          next_st.rvalid = 1'b1;
          next_st.rd_state = FNM_RD_DATA;
          next_st.rresp = FNM_RESP_OKAY;
          next_st.rdata = 32'h0000_0000;
          if (rd_idx < FNM_IDX_CFG) begin
            next_st.rdata = {8'h00, st.hold[rd_idx[1:0]]};
          end else if (rd_idx == FNM_IDX_CFG) begin
            next_st.rdata = {8'h00, st.shift};
          end else if (rd_idx == FNM_IDX_STATUS) begin
            next_st.rdata = {7'h00, sd_n_inst, 8'h00, 1'b0, st.bit_clk, st.clamped,
                             st.txd_s2, st.tx_bit, st.presc8, mode};
          end else begin
            next_st.rresp = FNM_RESP_SLVERR;
          end
        end
      end
      FNM_RD_DATA: begin
        if (S_AXI_RREADY) begin
          next_st.rvalid = 1'b0;
          next_st.rd_state = FNM_RD_IDLE;
        end
      end
      default: begin
        next_st.rd_state = FNM_RD_IDLE;
      end
    endcase
    next_st.arready = next_st.rd_state == FNM_RD_IDLE;
  end

  // State register
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from state
  assign S_AXI_AWREADY = st.awready;
  assign S_AXI_WREADY = st.wready;
  assign S_AXI_BVALID = st.bvalid;
  assign S_AXI_BRESP = st.bresp;
  assign S_AXI_ARREADY = st.arready;
  assign S_AXI_RVALID = st.rvalid;
  assign S_AXI_RDATA = st.rdata;
  assign S_AXI_RRESP = st.rresp;
  assign TRANSMIT_BIT_CLOCK = st.bit_clk;
  assign N_TOTAL = st.n_total;
  assign FB_COUNT_B = st.fb_b;
  assign FB_COUNT_A = st.fb_a;
  assign PRESC_EIGHT = st.presc8;
  assign POWER_CODE = st.power;
  assign OUTPUT_STAGE_ON = st.stage_on;

  // Checks
  chk_ask_power_code: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (mode == FNM_MOD_ASK) |=> (POWER_CODE == ($past(st.txd_s2) ? $past(high_code) : $past(low_code))))
    else $error("ASK power code does not follow the transmit bit");
  chk_ook_stage_off: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (mode == FNM_MOD_OOK && !st.txd_s2) |=> (!OUTPUT_STAGE_ON && POWER_CODE == 7'h00))
    else $error("OOK stage not off for a zero bit");
  chk_fsk_direction: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (mode == FNM_MOD_FSK && low_code != 7'h00 && !next_st.clamped)
    |=> ((N_TOTAL > $past(base[FNM_NTOT_W-1:0])) == $past(st.txd_s2)))
    else $error("FSK shift direction wrong");
  chk_min_divide: assert property (@(posedge CLOCK) disable iff (!RST_N)
    $past(RST_N) |-> (N_TOTAL[FNM_NTOT_W-1:FNM_SD_W] >= ($past(st.presc8) ? FNM_NMIN_P8 : FNM_NMIN_P4)))
    else $error("Divide below prescaler minimum");
  chk_latch_only: assert property (@(posedge CLOCK) disable iff (!RST_N)
    !$stable(st.hold) |-> $past(st.le_s2 && !st.le_d) || $past(st.wr_state == FNM_WR_COLLECT
      && st.aw_got && st.w_got && fnm_reg_idx(st.aw_addr) == FNM_IDX_CFG))
    else $error("Holding register changed without a latch event");
  chk_shift_msb: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (st.sclk_s2 && !st.sclk_d) |=> (st.shift[0] == $past(st.sdat_s2)
      && st.shift[FNM_WORD_W-1:1] == $past(st.shift[FNM_WORD_W-2:0])))
    else $error("Serial word not shifted MSB first");
  chk_bit_clock_rise: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (st.smp_tick && index_val != 7'h00 && next_st.idx_cnt == 7'h00)
    |=> (TRANSMIT_BIT_CLOCK && st.tx_bit == $past(st.txd_s2)))
    else $error("Bit clock not raised with a new bit");
  chk_write_resp: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (st.wr_state == FNM_WR_COLLECT && st.aw_got && st.w_got) |=> S_AXI_BVALID ##0 !S_AXI_AWREADY)
    else $error("Write response missing");
endmodule : fnm_modulation_ctrl
`default_nettype wire

/* File: rtl/fnm_pkg.sv */
// Shared constants and types for the fractional-N modulation controller
package fnm_pkg;
  // Configuration word and holding registers
  localparam int FNM_WORD_W = 24;
  localparam int FNM_HOLD_N = 0;
  localparam int FNM_HOLD_R = 1;
  localparam int FNM_HOLD_M = 2;
  localparam int FNM_HOLD_G = 3;
  // Divider holding register fields
  localparam int FNM_FRAC_LSB = 2;
  localparam int FNM_FRAC_W = 12;
  localparam int FNM_INT_LSB = 14;
  localparam int FNM_INT_W = 8;
  localparam int FNM_PRESC_BIT = 22;
  // Trim holding register field
  localparam int FNM_TRIM_LSB = 2;
  localparam int FNM_TRIM_W = 11;
  // Modulation holding register fields
  localparam int FNM_SEL_LOW_BIT = 2;
  localparam int FNM_SEL_HIGH_BIT = 3;
  localparam int FNM_HIGH_PWR_LSB = 4;
  localparam int FNM_LOW_PWR_LSB = 11;
  localparam int FNM_PWR_W = 7;
  localparam int FNM_EXP_LSB = 18;
  localparam int FNM_EXP_W = 3;
  // Bit-rate holding register fields
  localparam int FNM_DIVF_LSB = 2;
  localparam int FNM_DIVF_W = 8;
  localparam int FNM_INDEX_LSB = 10;
  localparam int FNM_INDEX_W = 7;
  // Divider arithmetic
  localparam int FNM_SD_W = 15;
  localparam int FNM_NTOT_W = 23;
  localparam logic [7:0] FNM_NMIN_P4 = 8'h1F;
  localparam logic [7:0] FNM_NMIN_P8 = 8'h5B;
  localparam logic [7:0] FNM_INT_MAX = 8'hFF;
  // Five-tap binomial Gaussian weights, sum 16
  localparam logic [4:0][3:0] FNM_GAUSS_TAPS = {4'h1, 4'h4, 4'h6, 4'h4, 4'h1};
  localparam logic signed [5:0] FNM_GAUSS_SUM = 6'sh10;
  // Phase comparator rate divider default
  localparam int FNM_PFD_DIV_DEF = 4;
  // Bus register map, byte addresses
  localparam logic [4:0] FNM_ADDR_HOLD_N = 5'h00;
  localparam logic [4:0] FNM_ADDR_CFG = 5'h10;
  localparam logic [4:0] FNM_ADDR_STATUS = 5'h14;
  localparam logic [2:0] FNM_IDX_CFG = 3'h4;
  localparam logic [2:0] FNM_IDX_STATUS = 3'h5;
  localparam logic [2:0] FNM_IDX_NONE = 3'h7;
  localparam logic [1:0] FNM_RESP_OKAY = 2'h0;
  localparam logic [1:0] FNM_RESP_SLVERR = 2'h2;
  // Modulation modes, {high select, low select}
  typedef enum logic [1:0] {
    FNM_MOD_FSK = 2'b00,
    FNM_MOD_GFSK = 2'b01,
    FNM_MOD_ASK = 2'b10,
    FNM_MOD_OOK = 2'b11
  } fnm_mod_t;
  // Bus channel states
  typedef enum logic {FNM_WR_COLLECT = 1'b0, FNM_WR_RESP = 1'b1} fnm_wr_t;
  typedef enum logic {FNM_RD_IDLE = 1'b0, FNM_RD_DATA = 1'b1} fnm_rd_t;
endpackage : fnm_pkg

/* File: rtl/fnm_sigma_delta.sv */
// First-order sigma-delta modulus generator for the feedback divider
`timescale 1ns/1ns
`default_nettype none
module fnm_sigma_delta
  import fnm_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic en,
  input wire logic [FNM_NTOT_W-1:0] n_total,
  output logic [8:0] n_inst
);
  // Accumulator and current modulus
  typedef struct packed {
    logic [FNM_SD_W-1:0] acc;
    logic [8:0] n_inst;
  } fnm_sd_t;

  fnm_sd_t st;
  fnm_sd_t next_st;
  logic [FNM_SD_W:0] sum; // Fraction sum with carry

  // Carry out of the 15-bit accumulator adds one to the integer
  always_comb begin
    next_st = st;
    sum = {1'b0, st.acc} + {1'b0, n_total[FNM_SD_W-1:0]};
    if (en) begin
      next_st.acc = sum[FNM_SD_W-1:0];
      next_st.n_inst = {1'b0, n_total[FNM_NTOT_W-1:FNM_SD_W]} + {8'h00, sum[FNM_SD_W]};
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign n_inst = st.n_inst;
endmodule : fnm_sigma_delta
`default_nettype wire

/* File: rtl/fnm_gauss.sv */
// Five-tap Gaussian pre-filter for the transmit bit stream
`timescale 1ns/1ns
`default_nettype none
module fnm_gauss
  import fnm_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic en,
  input wire logic bit_in,
  output logic signed [5:0] level
);
  // Sample history and filtered level
  typedef struct packed {
    logic [4:0] taps;
    logic signed [5:0] level;
  } fnm_gauss_t;

  fnm_gauss_t st;
  fnm_gauss_t next_st;
  logic [5:0] weight; // Weight of the ones in the window

  // Level spans -16 to +16 for all zeros to all ones
  always_comb begin
    next_st = st;
    weight = 6'h00;
    if (en) begin
      next_st.taps = {st.taps[3:0], bit_in};
    end
    for (int i = 0; i < 5; i++) begin
      if (next_st.taps[i]) begin
        weight = weight + {2'b00, FNM_GAUSS_TAPS[i]};
      end
    end
    if (en) begin
      next_st.level = $signed({weight[4:0], 1'b0}) - FNM_GAUSS_SUM;
    end
  end

  // State register, starts at the all-zero level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '{taps: 5'h00, level: -6'sh10};
    end else begin
      st <= next_st;
    end
  end

  assign level = st.level;
endmodule : fnm_gauss
`default_nettype wire

/* File: verif/fnm_host_model.sv */
// Host model that drives the transmit bit line
`timescale 1ns/1ns
`default_nettype none
module fnm_host_model (
  input wire logic clk,
  input wire logic bit_clock,
  input wire logic paced,
  input wire logic want_bit,
  output logic tx_bit
);
  logic last_clk; // Bit clock level seen one cycle ago
  initial tx_bit = 1'b0;
  initial last_clk = 1'b0;
  // Free mode follows the bench; paced mode moves only on a bit clock rise
  always @(posedge clk) begin
    last_clk <= bit_clock;
    if (!paced || (bit_clock && !last_clk)) begin
      tx_bit <= want_bit;
    end
  end
endmodule : fnm_host_model
`default_nettype wire

/* File: verif/tb_fnm_modulation_ctrl.sv */
// Self-checking bench for the modulation controller
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin bad_count++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module tb_fnm_modulation_ctrl;
  import fnm_pkg::*;
  logic clock = 1'b0, rst_n = 1'b0, ser_clk = 1'b0, ser_data = 1'b0, latch = 1'b0;
  logic paced = 1'b0, want = 1'b0, tx, mid;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [4:0] awaddr = 5'h00, araddr = 5'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata, d;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, bclk, presc8, stage_on;
  logic [1:0] bresp, rresp, r;
  logic [22:0] ntot;
  logic [6:0] cnt_b, pwr;
  logic [2:0] cnt_a;
  int bad_count = 0, checked = 0, cycles = 0, base;
  time t0;
  fnm_modulation_ctrl #(.PFD_DIV(1)) DUT (
    .CLOCK(clock), .RST_N(rst_n), .SER_CLK(ser_clk), .SER_DATA(ser_data), .LATCH_STROBE(latch),
    .TRANSMIT_BIT_IN(tx), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .TRANSMIT_BIT_CLOCK(bclk), .N_TOTAL(ntot),
    .FB_COUNT_B(cnt_b), .FB_COUNT_A(cnt_a), .PRESC_EIGHT(presc8), .POWER_CODE(pwr),
    .OUTPUT_STAGE_ON(stage_on)
  );
  fnm_host_model HOST (.clk(clock), .bit_clock(bclk), .paced(paced), .want_bit(want), .tx_bit(tx));
  // Clock and hang guard
  always #5 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      final_report();
    end
  end
  // Bus write, address and data offered together
  task automatic wr(input logic [4:0] a, input logic [31:0] v, input logic [3:0] s, output logic [1:0] rs);
    @(posedge clock);
    awaddr <= a;
    wdata <= v;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clock);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    rs = bresp;
    bready <= 1'b0;
  endtask : wr
  // Bus read
  task automatic rd(input logic [4:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clock);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    v = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask : rd
  // Config word through the bus
  task automatic cfg(input logic [23:0] w);
    wr(FNM_ADDR_CFG, {8'h00, w}, 4'hF, r);
    `CHK("cfg resp", FNM_RESP_OKAY, r)
  endtask : cfg
  // Modulation word, then mode readback
  task automatic setm(input logic [1:0] s, input logic [6:0] hi, input logic [6:0] lo, input logic [2:0] ex);
    cfg({3'h0, ex, lo, hi, s, 2'b10});
    rd(FNM_ADDR_STATUS, d, r);
    `CHK("mode", s, d[1:0])
  endtask : setm
  // Transmit bit change, then settle
  task automatic txb(input logic b);
    @(posedge clock);
    want <= b;
    repeat (8) @(posedge clock);
  endtask : txb
  // Serial word, MSB first, optional latch strobe
  task automatic ser(input logic [23:0] w, input logic ld);
    for (int i = 23; i >= 0; i--) begin
      @(posedge clock);
      ser_clk <= 1'b0;
      ser_data <= w[i];
      repeat (4) @(posedge clock);
      ser_clk <= 1'b1;
      repeat (3) @(posedge clock);
    end
    @(posedge clock);
    ser_clk <= 1'b0;
    latch <= ld;
    repeat (5) @(posedge clock);
    latch <= 1'b0;
    repeat (8) @(posedge clock);
  endtask : ser
  // Verdict and end of run
  task automatic final_report();
    $display("Comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report
  // Main sequence
  initial begin
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    repeat (4) @(posedge clock);
    `CHK("ntot reset", 23'(31 << 15), ntot)
    rd(5'h04, d, r);
    `CHK("trim reset", 32'h0000_0000, d)
    rd(5'h18, d, r);
    `CHK("unmapped resp", FNM_RESP_SLVERR, r)
    `CHK("unmapped data", 32'h0000_0000, d)
    wr(FNM_ADDR_HOLD_N, 32'h0000_0000, 4'hF, r);
    `CHK("ro resp", FNM_RESP_SLVERR, r)
    wr(FNM_ADDR_CFG, 32'h0000_0001, 4'h1, r);
    `CHK("strobe resp", FNM_RESP_SLVERR, r)
    base = (100 << 15) + (12'h800 << 3);
    cfg(24'((100 << 14) | (12'h800 << 2)));
    txb(1'b0);
    `CHK("ntot frac", 23'(base), ntot)
    cfg(24'((11'h7FF << 2) | 1));
    txb(1'b0);
    `CHK("ntot trim", 23'(base - 1), ntot)
    cfg(24'((255 << 14) | (12'hFFF << 2)));
    cfg(24'((11'h3FF << 2) | 1));
    txb(1'b0);
    `CHK("ntot max", 23'h7F_FFFF, ntot)
    cfg(24'((1 << 22) | (50 << 14)));
    txb(1'b0);
    `CHK("ntot p8 min", 23'(91 << 15), ntot)
    `CHK("presc", 1'b1, presc8)
    `CHK("count b", 7'h0B, cnt_b)
    `CHK("count a", 3'h3, cnt_a)
    cfg(24'((100 << 14) | (12'h800 << 2)));
    ser(24'((11'h005 << 2) | 1), 1'b0);
    `CHK("no latch", 23'(base + 1023), ntot)
    ser(24'((11'h005 << 2) | 1), 1'b1);
    base = base + 5;
    `CHK("serial trim", 23'(base), ntot)
    rd(5'h04, d, r);
    `CHK("hold trim", 32'h0000_0015, d)
    setm(FNM_MOD_FSK, 7'h55, 7'h0A, 3'h0);
    txb(1'b1);
    `CHK("fsk one", 23'(base + 80), ntot)
    txb(1'b0);
    `CHK("fsk zero", 23'(base - 80), ntot)
    setm(FNM_MOD_FSK, 7'h55, 7'h7F, 3'h0);
    txb(1'b1);
    `CHK("fsk max", 23'(base + 1016), ntot)
    setm(FNM_MOD_ASK, 7'h55, 7'h22, 3'h0);
    txb(1'b0);
    `CHK("ask low", 7'h22, pwr)
    txb(1'b1);
    `CHK("ask high", 7'h55, pwr)
    setm(FNM_MOD_OOK, 7'h55, 7'h22, 3'h0);
    `CHK("ook pwr", 7'h55, pwr)
    `CHK("ook on", 1'b1, stage_on)
    txb(1'b0);
    `CHK("ook off", 1'b0, stage_on)
    cfg(24'((4 << 10) | (2 << 2) | 3));
    setm(FNM_MOD_GFSK, 7'h55, 7'h00, 3'h3);
    paced <= 1'b1;
    want <= 1'b1;
    repeat (200) @(posedge clock);
    `CHK("gfsk one", 23'(base + 64), ntot)
    want <= 1'b0;
    mid = 1'b0;
    repeat (200) begin
      @(posedge clock);
      if (ntot > 23'(base - 64) && ntot < 23'(base + 64)) mid = 1'b1;
    end
    `CHK("gfsk shaped", 1'b1, mid)
    `CHK("gfsk zero", 23'(base - 64), ntot)
    @(posedge bclk);
    t0 = $time;
    @(posedge bclk);
    `CHK("bit period", 64'h50, $time - t0)
    final_report();
  end
endmodule : tb_fnm_modulation_ctrl
`default_nettype wire
